// File: rof_pkg.sv
// Function
// - ASCII, single and double float encodings
// - Single float: one 32-bit block per element
// - Binary string starts with one '#','0' header
// - Single: sign, 8 exponent, 23 fraction bits
// - Double: sign, 11 exponent, 52 fraction bits
// - Sign bit zero positive, one negative
// - Normal order byte 1 first; swapped reverses
// - Header never swapped, always sent first
// - ASCII ignores the swapped byte order setting
// - Any one, two or three elements selectable
// - New element selection replaces the old one
// - Selected elements always sent in fixed order
// - Channel reads zero when not scanning
// - Overflow reads +9.9e37 with no unit
// - Units on reading and channel, ASCII only
// - Non-buffer readings always sent as ASCII
package rof_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [11:0] ROF_ADDR_CTRL = 12'h000;
  localparam logic [11:0] ROF_ADDR_STATUS = 12'h004;
  localparam logic [11:0] ROF_ADDR_COUNT = 12'h008;

  // Control field positions and value after reset (ASCII, normal, reading)
  localparam int ROF_CTRL_ENC_LSB = 0;
  localparam int ROF_CTRL_SWAP_BIT = 2;
  localparam int ROF_CTRL_SEL_LSB = 4;
  localparam logic [31:0] ROF_CTRL_RESET = 32'h0000_0010;

  // Encodings selected by the control register
  localparam logic [1:0] ROF_ENC_ASCII = 2'h0;
  localparam logic [1:0] ROF_ENC_SINGLE_FLOAT = 2'h1;
  localparam logic [1:0] ROF_ENC_DOUBLE_FLOAT = 2'h2;

  // Element select bits
  localparam int ROF_SEL_RDG = 0;
  localparam int ROF_SEL_CHAN = 1;
  localparam int ROF_SEL_UNIT = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Characters and fixed values
  localparam logic [7:0] ROF_HDR_HASH = 8'h23;
  localparam logic [7:0] ROF_HDR_ZERO = 8'h30;
  localparam logic [7:0] ROF_CH_COMMA = 8'h2c;
  localparam logic [7:0] ROF_CH_LF = 8'h0a;
  localparam logic [7:0] ROF_CH_DIGIT0 = 8'h30;
  localparam logic [31:0] ROF_OVF_SP = 32'h7e94_f56a;
  localparam logic [63:0] ROF_OVF_DP = 64'h47d2_9ead_4000_0000;
  localparam logic [55:0] ROF_OVF_TXT = 56'h2b_392e_3945_3337;
  localparam logic [55:0] ROF_TAG_INT = 56'h49_4e54_4348_414e;
  localparam logic [55:0] ROF_TAG_EXT = 56'h45_5854_4348_414e;

  // Byte counts of each stage
  localparam logic [3:0] ROF_HDR_LEN = 4'h2;
  localparam logic [3:0] ROF_SP_BYTES = 4'h4;
  localparam logic [3:0] ROF_DP_BYTES = 4'h8;
  localparam logic [3:0] ROF_RDG_TXT_LEN = 4'hd;
  localparam logic [3:0] ROF_OVF_TXT_LEN = 4'h7;
  localparam logic [3:0] ROF_TAG_LEN = 4'h7;
  localparam logic [3:0] ROF_CHAN_DIGITS = 4'h3;
  localparam logic [3:0] ROF_ONE_LEN = 4'h1;

  // Exponent biases
  localparam logic [7:0] ROF_SP_BIAS = 8'h7f;
  localparam logic [10:0] ROF_DP_BIAS = 11'h3ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Stages, one-hot, in transmit order
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_HDR = 8'h02,
    ST_RDG = 8'h04,
    ST_UNIT = 8'h08,
    ST_COMMA = 8'h10,
    ST_CHAN = 8'h20,
    ST_CTAG = 8'h40,
    ST_TERM = 8'h80
  } rof_state_t;

  // One reading conversion from the reading source
  typedef struct packed {
    logic [103:0] rd_text;   // 13 ASCII chars, first char in top byte
    logic [31:0] value_sp;   // Reading as single float
    logic [63:0] value_dp;   // Reading as double float
    logic [31:0] unit_text;  // Up to 4 unit chars, first in top byte
    logic [2:0] unit_len;    // Number of unit chars used
    logic [9:0] chan;        // Channel number
    logic scanning;          // Scan in progress
    logic ext_chan;          // External channel
    logic overflow;          // Overflow measurement
    logic from_buffer;       // Reading comes from the buffer
  } rof_rec_t;

  // Effective settings frozen per record
  typedef struct packed {
    logic bin;
    logic dp;
    logic swap;
    logic [2:0] sel;
  } rof_cfg_t;

  // One output byte
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } rof_byte_t;

endpackage

// File: rof_formatter.sv
`timescale 1ns/1ps
module rof_formatter
  import rof_pkg::*;
#(
  parameter int AW = 12
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rec_valid,
  input wire rof_rec_t rec,
  output logic rec_ready,
  output logic out_valid,
  output logic [7:0] out_byte,
  output logic out_last,
  input wire logic out_ready
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  // Byte of a 13-char window, first char at the top
  function automatic logic [7:0] char_at(input logic [103:0] t, input logic [3:0] i);
    int pos;
    pos = 96 - 8 * int'(i);
    return t[pos +: 8];
  endfunction

  // Byte i of an n-byte word held in the low bits; byte 1 is the sign end
  function automatic logic [7:0] pick_byte(input logic [63:0] w, input logic [3:0] n,
                                           input logic [3:0] i, input logic swap);
    logic [3:0] sel;
    sel = swap ? i : 4'(n - i - 4'h1);
    return w[8 * int'(sel) +: 8];
  endfunction

  // Position of the leading one of a channel number
  function automatic logic [3:0] lead_one(input logic [9:0] c);
    logic [3:0] p;
    p = 4'h0;
    for (int k = 0; k < 10; k++) begin
      if (c[k]) begin
        p = 4'(k);
      end
    end
    return p;
  endfunction

  // Channel number as a positive single float
  function automatic logic [31:0] chan_sp(input logic [9:0] c);
    logic [3:0] p;
    logic [31:0] m;
    p = lead_one(c);
    m = {22'h0, c} << (5'd23 - 5'(p));
    if (c == 10'h0) begin
      return 32'h0;
    end
    return {1'b0, 8'(ROF_SP_BIAS + 8'(p)), m[22:0]};
  endfunction

  // Channel number as a positive double float
  function automatic logic [63:0] chan_dp(input logic [9:0] c);
    logic [3:0] p;
    logic [63:0] m;
    p = lead_one(c);
    m = {54'h0, c} << (6'd52 - 6'(p));
    if (c == 10'h0) begin
      return 64'h0;
    end
    return {1'b0, 11'(ROF_DP_BIAS + 11'(p)), m[51:0]};
  endfunction

  // Decimal digit of a channel number, hundreds first
  function automatic logic [7:0] dec_digit(input logic [9:0] v, input logic [3:0] i);
    logic [9:0] q;
    q = (i == 4'h0) ? v / 10'd100 : (i == 4'h1) ? (v / 10'd10) % 10'd10 : v % 10'd10;
    return 8'(ROF_CH_DIGIT0 + q[7:0]);
  endfunction

  // Stages a record passes through, one bit per stage
  function automatic logic [7:0] stage_en(input rof_cfg_t c, input rof_rec_t r);
    logic asc;
    logic any;
    logic [7:0] en;
    asc = !c.bin;
    any = c.sel[ROF_SEL_RDG] | c.sel[ROF_SEL_CHAN];
    en = 8'h00;
    en[1] = c.bin & any;
    en[2] = c.sel[ROF_SEL_RDG];
    en[3] = asc & c.sel[ROF_SEL_UNIT] & c.sel[ROF_SEL_RDG] & !r.overflow
            & (r.unit_len != 3'h0);
    en[4] = asc & c.sel[ROF_SEL_RDG] & c.sel[ROF_SEL_CHAN];
    en[5] = c.sel[ROF_SEL_CHAN];
    en[6] = asc & c.sel[ROF_SEL_UNIT] & c.sel[ROF_SEL_CHAN];
    en[7] = asc & any;
    return en;
  endfunction

  // First enabled stage after the current one, fixed order
  function automatic rof_state_t next_stage(input logic [7:0] en, input logic [7:0] cur);
    logic [7:0] m;
    m = en & ~(8'(cur << 1) - 8'h01);
    m = m & 8'(~m + 8'h01);
    return (m == 8'h00) ? ST_IDLE : rof_state_t'(m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_meta_ff;
  logic rst_sync_ff;

  // Async assert, clocked release
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_got_ff, w_got_ff;
  logic [AW-1:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [31:0] ctrl_ff;       // Encoding, byte order, element select
  logic [31:0] rec_count_ff;  // Records taken since reset
  rof_state_t state_ff;
  logic [1:0] cnt_ff;

  // Handshakes
  wire aw_hs = s_axi_awvalid & awready_ff;
  wire w_hs = s_axi_wvalid & wready_ff;
  wire ar_hs = s_axi_arvalid & arready_ff;
  // Write fires once both halves are held and the last answer was taken
  wire do_write = aw_got_ff & w_got_ff & !bvalid_ff;
  wire nxt_aw_got = (aw_got_ff | aw_hs) & !do_write;
  wire nxt_w_got = (w_got_ff | w_hs) & !do_write;
  wire nxt_bvalid = do_write | (bvalid_ff & !s_axi_bready);
  wire nxt_rvalid = ar_hs | (rvalid_ff & !s_axi_rready);

  // Address decode on the word address
  wire [11:0] wa = 12'({waddr_ff[AW-1:2], 2'b00});
  wire [11:0] ra = 12'({s_axi_araddr[AW-1:2], 2'b00});
  wire w_ctrl = (wa == ROF_ADDR_CTRL);
  wire w_ro = (wa == ROF_ADDR_STATUS) | (wa == ROF_ADDR_COUNT);
  wire r_ctrl = (ra == ROF_ADDR_CTRL);
  wire r_stat = (ra == ROF_ADDR_STATUS);
  wire r_cnt = (ra == ROF_ADDR_COUNT);
  wire r_hit = r_ctrl | r_stat | r_cnt;
  // Only byte 0 holds fields; other lanes read as zero
  wire [31:0] nxt_ctrl = (do_write & w_ctrl & wstrb_ff[0])
                         ? {24'h0, wdata_ff[7:0] & 8'h77} : ctrl_ff;
  wire [31:0] status_word = {28'h0, out_valid, cnt_ff, !state_ff[0]};
  wire [31:0] rd_word = r_ctrl ? ctrl_ff : r_stat ? status_word : r_cnt ? rec_count_ff : 32'h0;

  // Channel ready and valid flags
  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      arready_ff <= 1'b0;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
    end else begin
      awready_ff <= !nxt_aw_got;
      wready_ff <= !nxt_w_got;
      arready_ff <= !nxt_rvalid;
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      bvalid_ff <= nxt_bvalid;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // Payload capture and register storage
  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      waddr_ff <= '0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      bresp_ff <= 2'h0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h0;
      ctrl_ff <= ROF_CTRL_RESET;
    end else begin
      if (aw_hs) begin
        waddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        bresp_ff <= (w_ctrl | w_ro) ? 2'h0 : 2'h2; // Unmapped gives SLVERR
      end
      if (ar_hs) begin
        rdata_ff <= rd_word;
        rresp_ff <= r_hit ? 2'h0 : 2'h2;
      end
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Record intake and effective settings
  logic rec_ready_ff;
  logic [3:0] idx_ff;
  rof_rec_t rec_ff;
  rof_cfg_t cfg_ff;

  wire [1:0] enc = ctrl_ff[ROF_CTRL_ENC_LSB +: 2];
  // Only buffered readings may go out in binary
  wire enc_bin = rec.from_buffer
                 & ((enc == ROF_ENC_SINGLE_FLOAT) | (enc == ROF_ENC_DOUBLE_FLOAT));
  rof_cfg_t in_cfg;
  assign in_cfg.bin = enc_bin;
  assign in_cfg.dp = enc_bin & (enc == ROF_ENC_DOUBLE_FLOAT);
  assign in_cfg.swap = enc_bin & ctrl_ff[ROF_CTRL_SWAP_BIT];
  assign in_cfg.sel = ctrl_ff[ROF_CTRL_SEL_LSB +: 3];

  wire accept = rec_valid & rec_ready_ff;
  wire [7:0] en_now = stage_en(cfg_ff, rec_ff);
  wire [7:0] en_new = stage_en(in_cfg, rec);

  ////////////////////////////////////////////////////////////////////////////////
  // Stage length and current byte
  wire [3:0] nb = cfg_ff.dp ? ROF_DP_BYTES : ROF_SP_BYTES;
  // Not scanning reports channel zero
  wire [9:0] chan_val = rec_ff.scanning ? rec_ff.chan : 10'h0;
  // Overflow swaps in the fixed +9.9e37 value
  wire [63:0] rdg_word = rec_ff.overflow ? (cfg_ff.dp ? ROF_OVF_DP : {32'h0, ROF_OVF_SP})
                         : (cfg_ff.dp ? rec_ff.value_dp : {32'h0, rec_ff.value_sp});
  // Channel floats are built here with a zero sign
  wire [63:0] chan_word = cfg_ff.dp ? chan_dp(chan_val) : {32'h0, chan_sp(chan_val)};
  wire [103:0] rdg_text = rec_ff.overflow ? {ROF_OVF_TXT, 48'h0} : rec_ff.rd_text;
  wire [103:0] unit_win = {rec_ff.unit_text, 72'h0};
  wire [103:0] tag_win = {rec_ff.ext_chan ? ROF_TAG_EXT : ROF_TAG_INT, 48'h0};

  logic [3:0] stage_len;
  logic [7:0] cur_byte;

  // Length and byte of the active stage
  always_comb begin
    stage_len = ROF_ONE_LEN;
    cur_byte = 8'h00;
    unique case (state_ff)
      ST_IDLE: begin
        stage_len = ROF_ONE_LEN;
      end
      ST_HDR: begin
        // Header bytes never follow the byte order setting
        stage_len = ROF_HDR_LEN;
        cur_byte = (idx_ff == 4'h0) ? ROF_HDR_HASH : ROF_HDR_ZERO;
      end
      ST_RDG: begin
        if (cfg_ff.bin) begin
          stage_len = nb;
          cur_byte = pick_byte(rdg_word, nb, idx_ff, cfg_ff.swap);
        end else begin
          stage_len = rec_ff.overflow ? ROF_OVF_TXT_LEN : ROF_RDG_TXT_LEN;
          cur_byte = char_at(rdg_text, idx_ff);
        end
      end
      ST_UNIT: begin
        stage_len = {1'b0, rec_ff.unit_len};
        cur_byte = char_at(unit_win, idx_ff);
      end
      ST_COMMA: begin
        cur_byte = ROF_CH_COMMA;
      end
      ST_CHAN: begin
        if (cfg_ff.bin) begin
          stage_len = nb;
          cur_byte = pick_byte(chan_word, nb, idx_ff, cfg_ff.swap);
        end else begin
          stage_len = ROF_CHAN_DIGITS;
          cur_byte = dec_digit(chan_val, idx_ff);
        end
      end
      ST_CTAG: begin
        stage_len = ROF_TAG_LEN;
        cur_byte = char_at(tag_win, idx_ff);
      end
      ST_TERM: begin
        cur_byte = ROF_CH_LF;
      end
      default: begin
        stage_len = ROF_ONE_LEN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  wire buf_room = (cnt_ff != 2'h2);
  wire emit = !state_ff[0] & buf_room;
  wire stage_done = (idx_ff == 4'(stage_len - 4'h1));
  wire rof_state_t after = next_stage(en_now, state_ff);
  wire rof_state_t first = next_stage(en_new, ST_IDLE);
  wire rof_state_t nxt_state = accept ? first
                               : (emit & stage_done) ? after : state_ff;
  wire [3:0] nxt_idx = (emit & !stage_done) ? 4'(idx_ff + 4'h1)
                       : (emit | accept) ? 4'h0 : idx_ff;
  rof_byte_t push_item;
  assign push_item.data = cur_byte;
  assign push_item.last = stage_done & (after == ST_IDLE);

  // Stage, index and ready flag
  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff <= ST_IDLE;
      idx_ff <= 4'h0;
      rec_ready_ff <= 1'b0;
      rec_count_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      rec_ready_ff <= (nxt_state == ST_IDLE);
      rec_count_ff <= accept ? 32'(rec_count_ff + 32'h1) : rec_count_ff;
    end
  end

  // Record and settings frozen for the whole string
  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rec_ff <= '0;
      cfg_ff <= '0;
    end else if (accept) begin
      rec_ff <= rec;
      cfg_ff <= in_cfg;
    end
  end

  assign rec_ready = rec_ready_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer; a receiver stall backs up into the sequencer
  rof_byte_t head_ff;
  rof_byte_t tail_ff;
  logic out_valid_ff;

  wire pop = out_valid_ff & out_ready;
  wire [1:0] nxt_cnt = 2'(cnt_ff + {1'b0, emit} - {1'b0, pop});
  // Head loads the new byte when it would otherwise be empty
  wire head_from_in = emit & ((cnt_ff == 2'h0) | (pop & (cnt_ff == 2'h1)));
  wire head_from_tail = pop & (cnt_ff == 2'h2);
  wire tail_load = emit & (((cnt_ff == 2'h1) & !pop) | head_from_tail);

  // Shift structure keeps the output straight off a flop
  always_ff @(posedge clock or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      head_ff <= '0;
      tail_ff <= '0;
      cnt_ff <= 2'h0;
      out_valid_ff <= 1'b0;
    end else begin
      head_ff <= head_from_in ? push_item : head_from_tail ? tail_ff : head_ff;
      tail_ff <= tail_load ? push_item : tail_ff;
      cnt_ff <= nxt_cnt;
      out_valid_ff <= (nxt_cnt != 2'h0);
    end
  end

  assign out_valid = out_valid_ff;
  assign out_byte = head_ff.data;
  assign out_last = head_ff.last;

endmodule

// File: rof_monitor.sv
`timescale 1ns/1ps
module rof_monitor
  import rof_pkg::*;
#(
  parameter int AW = 12
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic rec_valid,
  input wire logic rec_ready,
  input wire logic out_valid,
  input wire logic [7:0] out_byte,
  input wire logic out_last,
  input wire logic out_ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////////
  // Tracks string starts to check the header pair
  logic start_ff;
  logic hdr_ff;
  wire take = out_valid && out_ready;
  wire nxt_hdr = start_ff && (out_byte == ROF_HDR_HASH);
  // Bench texts never start with a hash, so a start hash is a header
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      start_ff <= 1'b1;
      hdr_ff <= 1'b0;
    end else if (take) begin
      start_ff <= out_last;
      hdr_ff <= nxt_hdr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_hdr_second_zero: assert property (out_valid && hdr_ff |->
    out_byte == ROF_HDR_ZERO && !out_last)
    else $error("header second byte wrong");
  a_out_stall_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_byte) && $stable(out_last))
    else $error("output byte changed during stall");
  a_rec_ready_hold: assert property (rec_ready && !rec_valid |=> rec_ready)
    else $error("idle formatter went busy");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken with read pending");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer not held");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 12'h00c
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

bind rof_formatter rof_monitor #(.AW(AW)) i_mon (
  .clock(clock), .rst_b(rst_b), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .rec_valid(rec_valid), .rec_ready(rec_ready),
  .out_valid(out_valid), .out_byte(out_byte), .out_last(out_last), .out_ready(out_ready)
);

// File: rof_host_model.sv
`timescale 1ns/1ps
module rof_host_model (
  input wire logic clock,
  input wire logic rst_b,
  output logic out_ready
);
  integer hseed = 12;
  // Host stalls about one cycle in four so the buffer fills
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= ($random(hseed) & 3) != 0;
    end
  end
endmodule

// File: reading_output_formatter_tb_top.sv
`timescale 1ns/1ps
module reading_output_formatter_tb_top
  import rof_pkg::*;
;
  logic clock, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, ctrl;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic rec_valid, rec_ready, out_valid, out_last, out_ready;
  rof_rec_t rec, r;
  logic [7:0] out_byte;
  logic [255:0] rnd;
  rof_byte_t exp_q[$];
  rof_byte_t e;
  integer seed = 12;
  int n_mismatch = 0;
  int n_tests = 0;

  rof_formatter i_dut (
    .clock(clock), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rec_valid(rec_valid),
    .rec(rec), .rec_ready(rec_ready), .out_valid(out_valid), .out_byte(out_byte),
    .out_last(out_last), .out_ready(out_ready)
  );
  rof_host_model i_host (.clock(clock), .rst_b(rst_b), .out_ready(out_ready));

  always #5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Master offers address and data together, releases each once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Channel number as a float, worked out bit by bit
  function automatic logic [63:0] ch_flt(input logic [9:0] n, input logic dp);
    int p;
    logic [63:0] f;
    p = 9;
    if (n == 10'h0) return 64'h0;
    while (!n[p]) p--;
    f = {54'h0, n} << (52 - p);
    if (dp) return {1'b0, ROF_DP_BIAS + 11'(p), f[51:0]};
    return {32'h0, 1'b0, ROF_SP_BIAS + 8'(p), f[51:29]};
  endfunction

  // Bytes right-aligned in v, most significant first unless reversed
  task automatic pushn(input logic [103:0] v, input int n, input logic rev);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({1'b0, rev ? v[8*i +: 8] : v[8*(n-1-i) +: 8]});
    end
  endtask

  task automatic note_rec(input logic [31:0] c, input rof_rec_t q);
    logic bin, dp, rdg, ch, un;
    int n0;
    logic [9:0] cv;
    n0 = exp_q.size();
    bin = q.from_buffer && c[1:0] inside {ROF_ENC_SINGLE_FLOAT, ROF_ENC_DOUBLE_FLOAT};
    dp = c[1:0] == ROF_ENC_DOUBLE_FLOAT;
    rdg = c[4];
    ch = c[5];
    un = c[6] && !bin;
    cv = q.scanning ? q.chan : 10'h0;
    if (bin && (rdg || ch)) begin
      pushn({88'h0, ROF_HDR_HASH, ROF_HDR_ZERO}, 2, 1'b0);
      if (rdg) pushn(dp ? (q.overflow ? ROF_OVF_DP : q.value_dp)
        : (q.overflow ? ROF_OVF_SP : q.value_sp), dp ? 8 : 4, c[2]);
      if (ch) pushn(ch_flt(cv, dp), dp ? 8 : 4, c[2]);
    end else if (rdg || ch) begin
      // Text ignores the swap bit
      if (rdg) pushn(q.overflow ? ROF_OVF_TXT : q.rd_text,
        q.overflow ? 7 : 13, 1'b0);
      if (rdg && un && !q.overflow)
        pushn(q.unit_text >> (8*(4-q.unit_len)), q.unit_len, 1'b0);
      if (rdg && ch) exp_q.push_back({1'b0, ROF_CH_COMMA});
      if (ch) pushn({8'(8'h30 + cv/100), 8'(8'h30 + cv/10%10), 8'(8'h30 + cv%10)}, 3, 1'b0);
      if (ch && un) pushn(q.ext_chan ? ROF_TAG_EXT : ROF_TAG_INT, 7, 1'b0);
      exp_q.push_back({1'b0, ROF_CH_LF});
    end
    if (exp_q.size() > n0) exp_q[$].last = 1'b1;
  endtask

  // Bytes are noted at the accepting edge, where settings freeze
  task automatic send(input rof_rec_t q);
    rec <= q;
    rec_valid <= 1'b1;
    do @(posedge clock); while (!rec_ready);
    note_rec(ctrl, q);
    rec_valid <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Byte watcher takes the oldest note for each byte taken
  always @(posedge clock) begin
    if (rst_b && out_valid && out_ready) begin
      if (exp_q.size() == 0) begin
        chk(64'h1, 64'h0);
      end else begin
        e = exp_q.pop_front();
        chk({out_last, out_byte}, e);
      end
    end
  end

  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    end_of_test;
  end

  initial begin
    clock = 0;
    rst_b = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rec_valid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, ctrl} = '0;
    rec = '0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    repeat (5) @(posedge clock);
    axi_rd(ROF_ADDR_CTRL, ROF_CTRL_RESET, 2'h0);
    axi_wr(ROF_ADDR_CTRL, 32'hffff_ffff, 4'he, 2'h0);
    axi_rd(ROF_ADDR_CTRL, ROF_CTRL_RESET, 2'h0);
    axi_wr(12'h00c, 32'h1, 4'hf, 2'h2);
    axi_rd(12'h00c, 32'h0, 2'h2);
    axi_wr(ROF_ADDR_CTRL, 32'hffff_ffff, 4'hf, 2'h0);
    axi_rd(ROF_ADDR_CTRL, 32'h0000_0077, 2'h0);
    $display("test registers done");
    // Every encoding, swap and selection, with random records
    for (int i = 0; i < 64; i++) begin
      ctrl = {25'h0, i[5:3], 1'b0, i[2], i[1:0]};
      axi_wr(ROF_ADDR_CTRL, ctrl, 4'hf, 2'h0);
      rnd = {$random(seed), $random(seed), $random(seed), $random(seed),
             $random(seed), $random(seed), $random(seed), $random(seed)};
      r = rnd[248:0];
      r.rd_text[103:96] = 8'h2b;
      r.unit_len = 3'($unsigned($random(seed)) % 5);
      r.chan = 10'($unsigned($random(seed)) % 1000);
      send(r);
    end
    for (int k = 0; k < 5000 && exp_q.size() > 0; k++) @(posedge clock);
    chk(exp_q.size(), 0);
    axi_rd(ROF_ADDR_COUNT, 32'd64, 2'h0);
    axi_rd(ROF_ADDR_STATUS, 32'h0, 2'h0);
    $display("test stream done");
    end_of_test;
  end
endmodule
